// >>> hdl/upat_pkg.sv
package upat_pkg;

	// -----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// -----------------------------------------------------------------
	localparam logic [11:0] CTRL_IDX    = 12'h550;  // sequencer control
	localparam logic [11:0] WORD_LO_IDX = 12'h551;  // word one low byte
	localparam logic [11:0] WORD_HI_IDX = 12'h558;  // word four high byte
	localparam logic [11:0] STAT_IDX    = 12'h55F;  // sequencer status

	// -----------------------------------------------------------------
	// control fields, codes and reset values
	// -----------------------------------------------------------------
	localparam int          SEQ_SEL_POS = 7;         // custom_sequence_select
	localparam int          TPS_LSB     = 0;         // test_pattern_select lsb
	localparam logic [3:0]  TPS_USER    = 4'h8;      // user-pattern code
	localparam logic [7:0]  CTRL_WMASK  = 8'hBF;     // bit 6 reserved, reads 0
	localparam logic [7:0]  CTRL_RST    = 8'h00;     // control reset value
	localparam logic [15:0] WORD_RST    = 16'h0000;  // custom word reset value
	localparam logic [15:0] ZERO_WORD   = 16'h0000;  // single-shot tail value

	// sequencer states, gray along idle-w1-w2-w3-w4-done
	typedef enum logic [2:0]
	{
		SEQ_IDLE = 3'h0,
		SEQ_W1   = 3'h1,
		SEQ_W2   = 3'h3,
		SEQ_W3   = 3'h2,
		SEQ_W4   = 3'h6,
		SEQ_DONE = 3'h7
	} seq_e;

	// apb request from the master
	typedef struct packed
	{
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [15:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	// apb answer to the master
	typedef struct packed
	{
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_s;

	// whole state of the sequencer
	typedef struct packed
	{
		logic [7:0]       ctrl;
		logic [3:0][15:0] words;
		seq_e             seq;
		logic [15:0]      out;
		logic             active;
		apb_rsp_s         rsp;
	} state_s;

	localparam state_s ST_RST = '{ctrl: CTRL_RST, words: {4{WORD_RST}}, seq: SEQ_IDLE,
		out: ZERO_WORD, active: 1'b0, rsp: '0};

endpackage

// >>> hdl/user_test_pattern_sequencer.sv
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps

// Functional notes
// [RULE1] sequence select only matters in user mode
// [RULE2] select clear: words one..four, repeat forever
// [RULE3] select set: words one..four once, then zeros
// [RULE4] each word from its own byte pair
// [RULE5] select code 1000 enters user pattern mode
// [RULE6] 16-bit words, low/high bytes, reset zero
// [RULE7] every sequence starts with word one
module user_test_pattern_sequencer
(
	input  wire logic              clock,            // 50 MHz sample clock
	input  wire logic              sys_rst,          // sync reset, high
	input  wire upat_pkg::apb_req_s req,             // apb request
	output      upat_pkg::apb_rsp_s rsp,             // apb answer
	input  wire logic [15:0]       conv_sample,      // converter sample in
	output      logic [15:0]       out_sample,       // sample to framer
	output      logic              out_user_active   // user pattern on out
);

	// -----------------------------------------------------------------
	// helper functions
	// -----------------------------------------------------------------

	// true when the index falls on a custom word byte
	function automatic logic word_hit(input logic [11:0] idx);
		word_hit = (idx >= upat_pkg::WORD_LO_IDX) && (idx <= upat_pkg::WORD_HI_IDX);
	endfunction

	// which of the four words an index belongs to
	function automatic logic [1:0] word_num(input logic [11:0] idx);
		logic [11:0] off;
		off = idx - upat_pkg::WORD_LO_IDX;
		word_num = off[2:1];
	endfunction

	// low byte sits at the odd index, high byte at the even one
	function automatic logic word_high(input logic [11:0] idx);
		word_high = ~idx[0];
	endfunction

	// -----------------------------------------------------------------
	// state and decode
	// -----------------------------------------------------------------
	upat_pkg::state_s s_r;      // all registered state
	upat_pkg::state_s s_nxt;    // next value of the state

	logic [11:0] idx;           // word index of the bus address
	logic        acc;           // access phase present
	logic        wr_go;         // write completes at this edge
	logic        user_now;      // control selects user pattern mode
	logic        sel_now;       // single-shot selected

	assign idx      = req.paddr[13:2];
	assign acc      = req.psel & req.penable;
	// a write lands only on the edge where pready is seen high
	assign wr_go    = acc & req.pwrite & s_r.rsp.pready;
	assign user_now = s_r.ctrl[upat_pkg::TPS_LSB +: 4] == upat_pkg::TPS_USER;   // RULE5
	// the select bit is only looked at together with the user code
	assign sel_now  = user_now & s_r.ctrl[upat_pkg::SEQ_SEL_POS];                // RULE1

	// -----------------------------------------------------------------
	// next-state logic: bus slave, registers, sequencer
	// -----------------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		// pready is a one-cycle answer; data holds until next access
		s_nxt.rsp.pready  = 1'b0;
		s_nxt.rsp.pslverr = 1'b0;

		// answer one cycle into the access phase
		if (acc && !s_r.rsp.pready)
		begin
			s_nxt.rsp.pready = 1'b1;
			if (idx == upat_pkg::CTRL_IDX)
			begin
				// control readback, reserved bit reads zero
				s_nxt.rsp.prdata = {24'h000000, s_r.ctrl};
			end
			else if (word_hit(idx))
			begin
				// one byte of one custom word
				s_nxt.rsp.prdata = word_high(idx)
					? {24'h000000, s_r.words[word_num(idx)][15:8]}
					: {24'h000000, s_r.words[word_num(idx)][7:0]};
			end
			else if (idx == upat_pkg::STAT_IDX)
			begin
				// live sequencer state for software
				s_nxt.rsp.prdata = {27'h0000000, s_r.seq == upat_pkg::SEQ_DONE, s_r.active, s_r.seq};
			end
			else
			begin
				// unmapped: zero data and an error answer
				s_nxt.rsp.prdata  = 32'h0000_0000;
				s_nxt.rsp.pslverr = 1'b1;
			end
			// writes return no data, whatever the place
			if (req.pwrite)
			begin
				s_nxt.rsp.prdata = 32'h0000_0000;
			end
		end

		// register writes
		if (wr_go)
		begin
			if (idx == upat_pkg::CTRL_IDX)
			begin
				s_nxt.ctrl = req.pwdata[7:0] & upat_pkg::CTRL_WMASK;
			end
			else if (word_hit(idx))
			begin
				// each byte register feeds only its own half
				if (word_high(idx))
				begin
					s_nxt.words[word_num(idx)][15:8] = req.pwdata[7:0];   // RULE6
				end
				else
				begin
					s_nxt.words[word_num(idx)][7:0] = req.pwdata[7:0];    // RULE6
				end
			end
		end

		// sequencer walk
		case (s_r.seq)
			upat_pkg::SEQ_IDLE:
			begin
				// entering user mode always starts at word one
				s_nxt.seq = upat_pkg::SEQ_W1;                        // RULE7
			end
			upat_pkg::SEQ_W1:
			begin
				s_nxt.seq = upat_pkg::SEQ_W2;
			end
			upat_pkg::SEQ_W2:
			begin
				s_nxt.seq = upat_pkg::SEQ_W3;
			end
			upat_pkg::SEQ_W3:
			begin
				s_nxt.seq = upat_pkg::SEQ_W4;
			end
			upat_pkg::SEQ_W4:
			begin
				// repeat wraps, single shot parks in done
				s_nxt.seq = sel_now ? upat_pkg::SEQ_DONE : upat_pkg::SEQ_W1;   // RULE2 RULE3
			end
			upat_pkg::SEQ_DONE:
			begin
				// clearing the select bit restarts the cycle
				s_nxt.seq = sel_now ? upat_pkg::SEQ_DONE : upat_pkg::SEQ_W1;   // RULE3
			end
			default:
			begin
				s_nxt.seq = upat_pkg::SEQ_IDLE;
			end
		endcase
		// any other test mode parks the sequencer
		if (!user_now)
		begin
			s_nxt.seq = upat_pkg::SEQ_IDLE;                          // RULE5
		end

		// output word follows the next state so it leaves a flop
		case (s_nxt.seq)
			upat_pkg::SEQ_W1:   s_nxt.out = s_r.words[0];            // RULE4
			upat_pkg::SEQ_W2:   s_nxt.out = s_r.words[1];            // RULE4
			upat_pkg::SEQ_W3:   s_nxt.out = s_r.words[2];            // RULE4
			upat_pkg::SEQ_W4:   s_nxt.out = s_r.words[3];            // RULE4
			upat_pkg::SEQ_DONE: s_nxt.out = upat_pkg::ZERO_WORD;     // RULE3
			default:            s_nxt.out = conv_sample;             // RULE1
		endcase
		s_nxt.active = s_nxt.seq != upat_pkg::SEQ_IDLE;
	end

	// -----------------------------------------------------------------
	// state register
	// -----------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			s_r <= upat_pkg::ST_RST;                                 // RULE6
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state flops
	assign rsp             = s_r.rsp;
	assign out_sample      = s_r.out;
	assign out_user_active = s_r.active;

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	// outside user mode the converter sample passes
	property p_rule1;
		!user_now |=> (out_sample == $past(conv_sample)) && !out_user_active;
	endproperty
	a_rule1: assert property (p_rule1) else $error("sample not passed outside user mode"); // RULE1

	// the last word of a repeat cycle wraps to word one
	sequence s_repeat_last;
		user_now && !sel_now && s_r.seq == upat_pkg::SEQ_W4;
	endsequence
	property p_rule2;
		s_repeat_last |=> s_r.seq == upat_pkg::SEQ_W1 && out_sample == $past(s_r.words[0]);
	endproperty
	a_rule2: assert property (p_rule2) else $error("repeat did not wrap to word one"); // RULE2

	// single shot ends in zeros after word four
	sequence s_single_end;
		(user_now && sel_now && s_r.seq == upat_pkg::SEQ_W4) ##1 (s_r.seq == upat_pkg::SEQ_DONE);
	endsequence
	property p_rule3;
		s_single_end |-> out_sample == upat_pkg::ZERO_WORD;
	endproperty
	a_rule3: assert property (p_rule3) else $error("single shot tail not zero"); // RULE3

	// word three is taken from its own register pair
	property p_rule4;
		(user_now && s_r.seq == upat_pkg::SEQ_W2) |=> out_sample == $past(s_r.words[2]);
	endproperty
	a_rule4: assert property (p_rule4) else $error("wrong word after word two"); // RULE4

	// writing the user code starts the sequencer
	sequence s_enter;
		!user_now ##1 user_now;
	endsequence
	property p_rule5;
		s_enter |=> s_r.seq == upat_pkg::SEQ_W1 && out_user_active;
	endproperty
	a_rule5: assert property (p_rule5) else $error("user mode not entered"); // RULE5

	// a low-byte write leaves the high byte alone
	property p_rule6;
		(wr_go && idx == upat_pkg::WORD_LO_IDX) |=>
			s_r.words[0][7:0] == $past(req.pwdata[7:0]) && s_r.words[0][15:8] == $past(s_r.words[0][15:8]);
	endproperty
	a_rule6: assert property (p_rule6) else $error("low byte write wrong"); // RULE6

	// the first word after entry is word one
	property p_rule7;
		s_enter |=> out_sample == $past(s_r.words[0]);
	endproperty
	a_rule7: assert property (p_rule7) else $error("sequence did not start at word one"); // RULE7

endmodule

// >>> verif/link_rx_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// link receiver stand-in
// ----------------------------------------
module link_rx_model
(
	input wire logic        clock,     // sample clock
	input wire logic        sys_rst,   // sync reset, high
	input wire logic [15:0] rx_sample, // word from framer path
	input wire logic        rx_user    // user pattern flag
);
	logic [15:0] last_word_r;  // last word taken
	int          user_count_r; // user words taken

	// takes a word every edge: the real receiver has no back pressure
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			last_word_r  <= 16'h0000;
			user_count_r <= 0;
		end
		else
		begin
			last_word_r  <= rx_sample;
			user_count_r <= user_count_r + int'(rx_user);
		end
	end
endmodule

// >>> verif/user_test_pattern_sequencer_bench.sv
`timescale 1ns/1ps

// ----------------------------------------
// bench top
// ----------------------------------------
module user_test_pattern_sequencer_bench;
	logic               clock;           // 50 MHz
	logic               sys_rst;         // sync reset
	upat_pkg::apb_req_s req;             // apb request
	upat_pkg::apb_rsp_s rsp;             // apb answer
	logic [15:0]        conv_sample = 16'h1234; // converter samples
	logic [15:0]        out_sample;      // to framer
	logic               out_user_active; // user flag
	int                 err_count;       // mismatches
	int                 check_count;     // comparisons
	int                 cyc = 0;         // cycle counter
	int                 n;               // loop index
	logic [31:0]        rd;              // read data
	logic               rd_err;          // read slave error
	logic [15:0]        pat [4];         // custom words

	user_test_pattern_sequencer i_dut (.clock(clock), .sys_rst(sys_rst), .req(req), .rsp(rsp),
		.conv_sample(conv_sample), .out_sample(out_sample), .out_user_active(out_user_active));
	link_rx_model i_rx (.clock(clock), .sys_rst(sys_rst), .rx_sample(out_sample), .rx_user(out_user_active));

	// clock
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// samples change every cycle so a stale pass-through shows
	always @(posedge clock)
		conv_sample <= conv_sample + 16'h0101;

	// hang guard: far above the roughly 120 cycles needed
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_count++;
			test_done();
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer; request held until pready is sampled high
	task apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
		@(posedge clock);
		req.psel   <= 1'b1;
		req.pwrite <= wr;
		req.paddr  <= {2'b00, idx, 2'b00};
		req.pwdata <= {24'h000000, wd};
		@(posedge clock);
		req.penable <= 1'b1;
		// no cycle limit here: the bench timeout ends a hung wait
		do
		begin
			@(posedge clock);
		end
		while (rsp.pready !== 1'b1);
		check({31'h0, rsp.pready}, 32'h1);
		rd = rsp.prdata;
		rd_err = rsp.pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask

	// one output cycle; active flag compared only when asked
	task out_chk(input logic [15:0] exp, input logic act, input logic use_act);
		@(posedge clock);
		#1;
		check({16'h0000, out_sample}, {16'h0000, exp});
		if (use_act)
			check({31'h0, out_user_active}, {31'h0, act});
	endtask

	// pass-through: last cycle's converter sample
	task pass_chk();
		@(posedge clock);
		#1;
		check({16'h0000, out_sample}, {16'h0000, conv_sample - 16'h0101});
		check({31'h0, out_user_active}, 32'h0);
	endtask

	task test_done();
		$display("checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// main sequence
	initial
	begin
		sys_rst = 1'b1;
		req = '0;
		err_count = 0;
		check_count = 0;
		pat = '{16'hA55A, 16'h0FF0, 16'h8001, 16'h7E3C};
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		// registers: reset values, reserved bit, unmapped place
		apb(1'b0, upat_pkg::CTRL_IDX, 8'h00);
		check(rd, 32'h0);
		apb(1'b0, upat_pkg::WORD_HI_IDX, 8'h00);
		check(rd, 32'h0);
		apb(1'b1, upat_pkg::CTRL_IDX, 8'h70);
		apb(1'b0, upat_pkg::CTRL_IDX, 8'h00);
		check(rd, 32'h30);
		apb(1'b0, 12'h560, 8'h00);
		check({31'h0, rd_err}, 32'h1);
		check(rd, 32'h0);
		for (n = 0; n < 4; n++)
		begin
			apb(1'b1, upat_pkg::WORD_LO_IDX + 12'(2 * n), pat[n][7:0]);
			apb(1'b1, upat_pkg::WORD_LO_IDX + 12'(2 * n + 1), pat[n][15:8]);
		end
		apb(1'b0, upat_pkg::WORD_HI_IDX, 8'h00);
		check(rd, {24'h0, pat[3][15:8]});
		$display("test registers done");
		// other mode with select set: plain pass-through
		apb(1'b1, upat_pkg::CTRL_IDX, 8'h87);
		repeat (3) pass_chk();
		$display("test other mode done");
		// repeating user sequence
		apb(1'b1, upat_pkg::CTRL_IDX, 8'h08);
		for (n = 0; n < 9; n++)
			out_chk(pat[n % 4], 1'b1, 1'b1);
		apb(1'b1, upat_pkg::CTRL_IDX, 8'h00);
		pass_chk();
		$display("test repeat done");
		// single shot, then zeros
		apb(1'b1, upat_pkg::CTRL_IDX, 8'h88);
		for (n = 0; n < 4; n++)
			out_chk(pat[n], 1'b1, 1'b1);
		for (n = 0; n < 5; n++)
			out_chk(16'h0000, 1'b1, 1'b1);
		check({16'h0000, i_rx.last_word_r}, 32'h0);
		// status: done flag, active flag, done state code
		apb(1'b0, upat_pkg::STAT_IDX, 8'h00);
		check(rd, 32'h0000_001F);
		// clearing the select bit restarts at word one
		apb(1'b1, upat_pkg::CTRL_IDX, 8'h08);
		for (n = 0; n < 4; n++)
			out_chk(pat[n], 1'b1, 1'b1);
		check({31'h0, i_rx.user_count_r > 0}, 32'h1);
		$display("test single shot done");
		test_done();
	end
endmodule
